// ---- src/vccd_leaf_exec.sv ----
// execution logic of the virtual child count decrement leaf
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
module vccd_leaf_exec
   import vccd_pkg::*;
#(
   parameter int CNT_DEPTH = 8,
   parameter logic [63:0] PAGE_CONFLICT_CODE = 64'h1,
   parameter logic [63:0] INVALID_COUNTER_CODE = 64'h2
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [63:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [63:0] reg_rdata,
   // core context
   input wire vccd_ctx_s core_ctx,
   // page map lookup
   output logic map_req,
   output logic [63:0] map_tgt_addr,
   output logic [63:0] map_par_addr,
   input wire vccd_map_s map_rsp,
   // outcome
   output vccd_fault_s fault,
   output vccd_flags_s rflags,
   output logic done_pulse,
   output logic tgt_rw_nonencl,
   output logic par_rd_encl
);

   localparam int IW = $clog2(CNT_DEPTH);

   vccd_st_s s_q;
   vccd_st_s s_d;
   logic [63:0] cnt_q [CNT_DEPTH];
   logic cnt_we;
   logic [63:0] cnt_wval;
   logic [63:0] cur_cnt;
   logic [63:0] sel_cnt;
   logic [63:0] derived_parent_address;
   logic type_ok;
   logic start;
   vccd_stat_s stat;

   // counter of the parent being worked on, and the one software selected
   assign cur_cnt = cnt_q[s_q.cidx[IW-1:0]];
   assign sel_cnt = cnt_q[s_q.csel[IW-1:0]];
   assign start = reg_wr && (reg_addr == VCCD_REG_CTRL) && reg_wdata[VCCD_CTRL_START] &&
                  (s_q.st == VCCD_S_IDLE);
   assign stat = '{encl: s_q.flt.enclave_fault_error_bit, flg: s_q.flg,
                   kind: s_q.flt.kind, done: s_q.done, busy: s_q.busy};

   // parent derivation from the page map answer
   always_comb begin
      derived_parent_address = map_rsp.back_ptr;
      type_ok = 1'b1;
      if (f_child_type(map_rsp.page_type)) begin
         derived_parent_address = map_rsp.back_ptr;
      end else if (map_rsp.page_type == VCCD_CONTROL_PAGE_TYPE) begin
         derived_parent_address = map_rsp.tgt_phys;
      end else begin
         type_ok = 1'b0;
      end
   end

   // next state: register writes, reads and the leaf sequence
   always_comb begin
      s_d = s_q;
      s_d.done_p = 1'b0;
      s_d.map_req = 1'b0;
      s_d.rdata = '0;
      cnt_we = 1'b0;
      cnt_wval = cur_cnt;
      if (reg_wr && !s_q.busy) begin
         case (reg_addr)
            VCCD_REG_LEAF: begin
               s_d.result_register = reg_wdata;
            end
            VCCD_REG_TGT: begin
               s_d.target_page_pointer = reg_wdata;
            end
            VCCD_REG_PAR: begin
               s_d.parent_page_pointer = reg_wdata;
            end
            VCCD_REG_CSEL: begin
               s_d.csel = reg_wdata[7:0];
            end
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            VCCD_REG_LEAF: begin
               s_d.rdata = s_q.result_register;
            end
            VCCD_REG_TGT: begin
               s_d.rdata = s_q.target_page_pointer;
            end
            VCCD_REG_PAR: begin
               s_d.rdata = s_q.parent_page_pointer;
            end
            VCCD_REG_STAT: begin
               s_d.rdata = {53'h0, stat};
            end
            VCCD_REG_CSEL: begin
               s_d.rdata = {56'h0, s_q.csel};
            end
            VCCD_REG_CDAT: begin
               s_d.rdata = sel_cnt;
            end
            default: begin
               s_d.rdata = '0;
            end
         endcase
      end
      case (s_q.st)
         VCCD_S_IDLE: begin
            if (start) begin
               s_d.done = 1'b0;
               s_d.flt = '0;
               s_d.tgt_lin = f_lin(core_ctx, s_q.target_page_pointer);
               s_d.par_lin = f_lin(core_ctx, s_q.parent_page_pointer);
               if ((s_q.result_register != VCCD_LEAF_DEC) || !core_ctx.feature_en) begin
                  s_d = f_fault(s_d, VCCD_F_UD, 1'b0, '0);
               end else if (core_ctx.cpl != VCCD_PRIV_LEVEL) begin
                  s_d = f_fault(s_d, VCCD_F_GP, 1'b0, '0);
               end else if (!f_op_ok(core_ctx, s_q.target_page_pointer) ||
                            !f_op_ok(core_ctx, s_q.parent_page_pointer)) begin
                  s_d = f_fault(s_d, VCCD_F_GP, 1'b0, '0);
               end else if (!f_aligned(s_d.tgt_lin) || !f_aligned(s_d.par_lin)) begin
                  s_d = f_fault(s_d, VCCD_F_GP, 1'b0, '0);
               end else begin
                  s_d.busy = 1'b1;
                  s_d.map_req = 1'b1;
                  s_d.acc = 1'b1;
                  s_d.st = VCCD_S_LOOKUP;
               end
            end
         end
         VCCD_S_LOOKUP: begin
            s_d.st = VCCD_S_CHECK;
         end
         VCCD_S_CHECK: begin
            if (!map_rsp.tgt_in_prot) begin
               s_d = f_fault(s_d, VCCD_F_PF, 1'b1, s_q.tgt_lin);
            end else if (!map_rsp.par_in_prot) begin
               s_d = f_fault(s_d, VCCD_F_PF, 1'b1, s_q.par_lin);
            end else if (map_rsp.tgt_busy) begin
               s_d = f_finish(s_d, PAGE_CONFLICT_CODE, 1'b1);
            end else if (!map_rsp.valid) begin
               s_d = f_fault(s_d, VCCD_F_PF, 1'b1, s_q.tgt_lin);
            end else if (!type_ok) begin
               s_d = f_fault(s_d, VCCD_F_PF, 1'b1, s_q.tgt_lin);
            end else if (derived_parent_address != map_rsp.par_phys) begin
               s_d = f_fault(s_d, VCCD_F_GP, 1'b0, '0);
            end else begin
               s_d.cidx = map_rsp.par_phys[VCCD_PAGE_SHIFT +: 8];
               s_d.st = VCCD_S_UPDATE;
            end
         end
         VCCD_S_UPDATE: begin
            cnt_we = 1'b1;
            cnt_wval = cur_cnt - 64'h1;
            if (cur_cnt == '0) begin
               s_d.st = VCCD_S_RESTORE;
            end else begin
               s_d = f_finish(s_d, VCCD_RES_OK, 1'b0);
            end
         end
         VCCD_S_RESTORE: begin
            cnt_we = 1'b1;
            cnt_wval = cur_cnt + 64'h1;
            s_d = f_finish(s_d, INVALID_COUNTER_CODE, 1'b1);
         end
         default: begin
            s_d = VCCD_ST_RST;
         end
      endcase
   end

   // state register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= VCCD_ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // counter store: leaf update is atomic, software preload only while idle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < CNT_DEPTH; i++) begin
            cnt_q[i] <= '0;
         end
      end else if (cnt_we) begin
         cnt_q[s_q.cidx[IW-1:0]] <= cnt_wval;
      end else if (reg_wr && (reg_addr == VCCD_REG_CDAT) && !s_q.busy) begin
         cnt_q[s_q.csel[IW-1:0]] <= reg_wdata;
      end
   end

   // outputs straight from the state register
   assign reg_rdata = s_q.rdata;
   assign map_req = s_q.map_req;
   assign map_tgt_addr = s_q.tgt_lin;
   assign map_par_addr = s_q.par_lin;
   assign fault = s_q.flt;
   assign rflags = s_q.flg;
   assign done_pulse = s_q.done_p;
   assign tgt_rw_nonencl = s_q.acc;
   assign par_rd_encl = s_q.acc;

   // assertions
   property p_leaf_sel;
      @(posedge ref_clk) disable iff (!rstn)
      start && (s_q.result_register != VCCD_LEAF_DEC) |=> done_pulse && (fault.kind == VCCD_F_UD);
   endproperty
   a_leaf_sel: assert property (p_leaf_sel) else $error("bad leaf not refused");

   property p_priv;
      @(posedge ref_clk) disable iff (!rstn)
      start && (s_q.result_register == VCCD_LEAF_DEC) && core_ctx.feature_en &&
      (core_ctx.cpl != VCCD_PRIV_LEVEL) |=> done_pulse && (fault.kind == VCCD_F_GP);
   endproperty
   a_priv: assert property (p_priv) else $error("privilege fault missing");

   property p_seg32;
      @(posedge ref_clk) disable iff (!rstn)
      start && (s_q.result_register == VCCD_LEAF_DEC) && core_ctx.feature_en &&
      (core_ctx.cpl == VCCD_PRIV_LEVEL) && !core_ctx.mode64 && core_ctx.ds_unusable
      |=> (fault.kind == VCCD_F_GP) && !map_req;
   endproperty
   a_seg32: assert property (p_seg32) else $error("unusable segment not faulted");

   property p_canon;
      @(posedge ref_clk) disable iff (!rstn)
      start && (s_q.result_register == VCCD_LEAF_DEC) && core_ctx.feature_en &&
      (core_ctx.cpl == VCCD_PRIV_LEVEL) && core_ctx.mode64 &&
      !f_canon(s_q.target_page_pointer) |=> (fault.kind == VCCD_F_GP) && !map_req;
   endproperty
   a_canon: assert property (p_canon) else $error("non-canonical not faulted");

   property p_align;
      @(posedge ref_clk) disable iff (!rstn)
      start && (s_q.result_register == VCCD_LEAF_DEC) && core_ctx.feature_en &&
      (core_ctx.cpl == VCCD_PRIV_LEVEL) && core_ctx.mode64 &&
      (s_q.target_page_pointer[VCCD_PAGE_SHIFT-1:0] != '0) |=> fault.kind == VCCD_F_GP;
   endproperty
   a_align: assert property (p_align) else $error("misaligned target not faulted");

   property p_prot;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st == VCCD_S_CHECK) && !map_rsp.tgt_in_prot |=> (fault.kind == VCCD_F_PF) &&
      fault.enclave_fault_error_bit && (fault.addr == $past(s_q.tgt_lin));
   endproperty
   a_prot: assert property (p_prot) else $error("target page fault wrong");

   property p_conflict;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st == VCCD_S_CHECK) && map_rsp.tgt_in_prot && map_rsp.par_in_prot &&
      map_rsp.tgt_busy |=> rflags.zero_flag && (s_q.result_register == PAGE_CONFLICT_CODE) &&
      (fault.kind == VCCD_F_NONE) && (s_q.st == VCCD_S_IDLE);
   endproperty
   a_conflict: assert property (p_conflict) else $error("conflict outcome wrong");

   property p_self_parent;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st == VCCD_S_CHECK) && map_rsp.tgt_in_prot && map_rsp.par_in_prot &&
      !map_rsp.tgt_busy && map_rsp.valid && (map_rsp.page_type == VCCD_CONTROL_PAGE_TYPE) &&
      (map_rsp.tgt_phys == map_rsp.par_phys) |=> s_q.st == VCCD_S_UPDATE;
   endproperty
   a_self_parent: assert property (p_self_parent) else $error("control page not own parent");

   property p_underflow;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st == VCCD_S_UPDATE) && (cur_cnt == '0) |=> (s_q.st == VCCD_S_RESTORE) ##1
      ((cur_cnt == '0) && rflags.zero_flag && (s_q.result_register == INVALID_COUNTER_CODE));
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow not restored");

   property p_success;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st == VCCD_S_UPDATE) && (cur_cnt != '0) |=> (cur_cnt == $past(cur_cnt) - 64'h1) &&
      !rflags.zero_flag && (s_q.result_register == VCCD_RES_OK) && done_pulse;
   endproperty
   a_success: assert property (p_success) else $error("decrement outcome wrong");

   property p_clear;
      @(posedge ref_clk) disable iff (!rstn)
      done_pulse && (fault.kind == VCCD_F_NONE) |->
      !rflags.cf && !rflags.pf && !rflags.af && !rflags.of && !rflags.sf;
   endproperty
   a_clear: assert property (p_clear) else $error("arithmetic flags not cleared");

   property p_hold;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st == VCCD_S_CHECK) ##1 (done_pulse && (fault.kind != VCCD_F_NONE)) |->
      $stable(s_q.result_register) && $stable(rflags);
   endproperty
   a_hold: assert property (p_hold) else $error("fault changed result or flags");

   property p_access;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st != VCCD_S_IDLE) |-> tgt_rw_nonencl && par_rd_encl;
   endproperty
   a_access: assert property (p_access) else $error("access grant missing");

   property p_par_prot;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st == VCCD_S_CHECK) && map_rsp.tgt_in_prot && !map_rsp.par_in_prot |=>
      (fault.kind == VCCD_F_PF) && fault.enclave_fault_error_bit &&
      (fault.addr == map_par_addr);
   endproperty
   a_par_prot: assert property (p_par_prot) else $error("parent page fault wrong");

   property p_valid;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st == VCCD_S_CHECK) && map_rsp.tgt_in_prot && map_rsp.par_in_prot &&
      !map_rsp.tgt_busy && !map_rsp.valid |=> (fault.kind == VCCD_F_PF) &&
      fault.enclave_fault_error_bit && (fault.addr == map_tgt_addr);
   endproperty
   a_valid: assert property (p_valid) else $error("invalid entry not faulted");

   property p_type;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st == VCCD_S_CHECK) && map_rsp.tgt_in_prot && map_rsp.par_in_prot &&
      !map_rsp.tgt_busy && map_rsp.valid && !f_child_type(map_rsp.page_type) &&
      (map_rsp.page_type != VCCD_CONTROL_PAGE_TYPE) |=> (fault.kind == VCCD_F_PF) &&
      fault.enclave_fault_error_bit;
   endproperty
   a_type: assert property (p_type) else $error("wrong page type not faulted");

   property p_parent_match;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st == VCCD_S_CHECK) && map_rsp.tgt_in_prot && map_rsp.par_in_prot &&
      !map_rsp.tgt_busy && map_rsp.valid && f_child_type(map_rsp.page_type) &&
      (map_rsp.back_ptr != map_rsp.par_phys) |=> (fault.kind == VCCD_F_GP) &&
      !fault.enclave_fault_error_bit;
   endproperty
   a_parent_match: assert property (p_parent_match) else $error("parent mismatch missed");

   property p_child_parent;
      @(posedge ref_clk) disable iff (!rstn)
      (s_q.st == VCCD_S_CHECK) && map_rsp.tgt_in_prot && map_rsp.par_in_prot &&
      !map_rsp.tgt_busy && map_rsp.valid && f_child_type(map_rsp.page_type) &&
      (map_rsp.back_ptr == map_rsp.par_phys) |=> s_q.st == VCCD_S_UPDATE;
   endproperty
   a_child_parent: assert property (p_child_parent) else $error("back-pointer parent refused");

   property p_start_end;
      @(posedge ref_clk) disable iff (!rstn)
      start |=> done_pulse != map_req;
   endproperty
   a_start_end: assert property (p_start_end) else $error("start left no outcome");

endmodule

// ---- src/vccd_pkg.sv ----
// constants, types and carriers for the virtual child count decrement leaf
// Contract
// - leaf index 00h decrements; feature bit needed
// - runs only at privilege level zero
// - both operands use data segment, no override
// - misaligned operand gives general protection fault
// - target outside protected memory gives page fault
// - parent outside protected memory gives page fault
// - busy target: zero flag, conflict code, skip
// - invalid map entry gives enclave page fault
// - child types take parent from back-pointer
// - control page is its own parent
// - any other page type gives page fault
// - parent mismatch gives general protection fault
// - atomic decrement; underflow restores and reports
// - zero flag only on conflict or underflow
// - completion clears carry, parity, aux, overflow, sign
// - counter and parent address are 64 bits
// - 32-bit mode: limit or unusable segment faults
// - 64-bit mode: non-canonical address faults
// - grant target read/write, parent enclave read
package vccd_pkg;

   // register indices on the plain register port
   localparam logic [3:0] VCCD_REG_LEAF = 4'h0;
   localparam logic [3:0] VCCD_REG_TGT = 4'h1;
   localparam logic [3:0] VCCD_REG_PAR = 4'h2;
   localparam logic [3:0] VCCD_REG_CTRL = 4'h3;
   localparam logic [3:0] VCCD_REG_STAT = 4'h4;
   localparam logic [3:0] VCCD_REG_CSEL = 4'h5;
   localparam logic [3:0] VCCD_REG_CDAT = 4'h6;
   localparam int VCCD_CTRL_START = 0;

   // leaf index, result value and address geometry
   localparam logic [63:0] VCCD_LEAF_DEC = 64'h0;
   localparam logic [63:0] VCCD_RES_OK = 64'h0;
   localparam logic [1:0] VCCD_PRIV_LEVEL = 2'h0;
   localparam int VCCD_PAGE_SHIFT = 12;
   localparam int VCCD_VA_BITS = 48;

   // page map type codes
   localparam logic [7:0] VCCD_CONTROL_PAGE_TYPE = 8'h00;
   localparam logic [7:0] VCCD_REGULAR_PAGE_TYPE = 8'h01;
   localparam logic [7:0] VCCD_THREAD_CONTROL_PAGE_TYPE = 8'h02;
   localparam logic [7:0] VCCD_TRIMMED_PAGE_TYPE = 8'h04;
   localparam logic [7:0] VCCD_FIRST_SHADOW_STACK_TYPE = 8'h05;
   localparam logic [7:0] VCCD_LATER_SHADOW_STACK_TYPE = 8'h06;

   typedef enum logic [4:0] {
      VCCD_S_IDLE = 5'h01,
      VCCD_S_LOOKUP = 5'h02,
      VCCD_S_CHECK = 5'h04,
      VCCD_S_UPDATE = 5'h08,
      VCCD_S_RESTORE = 5'h10
   } vccd_state_e;

   typedef enum logic [1:0] {
      VCCD_F_NONE = 2'h0,
      VCCD_F_GP = 2'h1,
      VCCD_F_PF = 2'h2,
      VCCD_F_UD = 2'h3
   } vccd_fault_e;

   // core context seen when the leaf starts
   typedef struct packed {
      logic [1:0] cpl;
      logic mode64;
      logic feature_en;
      logic ds_unusable;
      logic seg_override;
      logic [63:0] ds_base;
      logic [31:0] ds_limit;
   } vccd_ctx_s;

   // page map answer for the two linear addresses
   typedef struct packed {
      logic tgt_in_prot;
      logic par_in_prot;
      logic tgt_busy;
      logic valid;
      logic [7:0] page_type;
      logic [63:0] back_ptr;
      logic [63:0] tgt_phys;
      logic [63:0] par_phys;
   } vccd_map_s;

   typedef struct packed {
      logic zero_flag;
      logic cf;
      logic pf;
      logic af;
      logic of;
      logic sf;
   } vccd_flags_s;

   typedef struct packed {
      vccd_fault_e kind;
      logic enclave_fault_error_bit;
      logic [63:0] addr;
   } vccd_fault_s;

   // status word layout, low bits of the status register
   typedef struct packed {
      logic encl;
      vccd_flags_s flg;
      vccd_fault_e kind;
      logic done;
      logic busy;
   } vccd_stat_s;

   typedef struct packed {
      vccd_state_e st;
      logic [63:0] result_register;
      logic [63:0] target_page_pointer;
      logic [63:0] parent_page_pointer;
      logic [7:0] csel;
      logic busy;
      logic done;
      vccd_fault_s flt;
      vccd_flags_s flg;
      logic [63:0] rdata;
      logic map_req;
      logic [63:0] tgt_lin;
      logic [63:0] par_lin;
      logic [7:0] cidx;
      logic acc;
      logic done_p;
   } vccd_st_s;

   localparam vccd_st_s VCCD_ST_RST = '{st: VCCD_S_IDLE, default: '0};

   // upper address bits all copies of the top valid bit
   function automatic logic f_canon(input logic [63:0] a);
      return (&a[63:VCCD_VA_BITS-1]) | ~(|a[63:VCCD_VA_BITS-1]);
   endfunction

   // operand passes the mode's segment or canonical check
   function automatic logic f_op_ok(input vccd_ctx_s c, input logic [63:0] a);
      if (c.mode64) begin
         return f_canon(a);
      end
      return !c.ds_unusable && (a[31:0] <= c.ds_limit);
   endfunction

   // linear address from the data segment, overrides ignored
   function automatic logic [63:0] f_lin(input vccd_ctx_s c, input logic [63:0] a);
      if (c.mode64) begin
         return a;
      end
      return {32'h0, c.ds_base[31:0] + a[31:0]};
   endfunction

   function automatic logic f_aligned(input logic [63:0] a);
      return a[VCCD_PAGE_SHIFT-1:0] == '0;
   endfunction

   // types whose parent is the recorded back-pointer
   function automatic logic f_child_type(input logic [7:0] t);
      return (t == VCCD_REGULAR_PAGE_TYPE) || (t == VCCD_THREAD_CONTROL_PAGE_TYPE) ||
             (t == VCCD_TRIMMED_PAGE_TYPE) || (t == VCCD_FIRST_SHADOW_STACK_TYPE) ||
             (t == VCCD_LATER_SHADOW_STACK_TYPE);
   endfunction

   // end the leaf with a fault, result and flags untouched
   function automatic vccd_st_s f_fault(input vccd_st_s s, input vccd_fault_e k,
                                        input logic e, input logic [63:0] a);
      vccd_st_s r;
      r = s;
      r.flt.kind = k;
      r.flt.enclave_fault_error_bit = e;
      r.flt.addr = a;
      r.st = VCCD_S_IDLE;
      r.busy = 1'b0;
      r.done = 1'b1;
      r.done_p = 1'b1;
      r.acc = 1'b0;
      return r;
   endfunction

   // end the leaf without fault: result, zero flag, other flags cleared
   function automatic vccd_st_s f_finish(input vccd_st_s s, input logic [63:0] res,
                                         input logic z);
      vccd_st_s r;
      r = s;
      r.result_register = res;
      r.flg = '{zero_flag: z, default: 1'b0};
      r.st = VCCD_S_IDLE;
      r.busy = 1'b0;
      r.done = 1'b1;
      r.done_p = 1'b1;
      r.acc = 1'b0;
      return r;
   endfunction

endpackage

// ---- verif/test_virtual_child_count_decrement.sv ----
// self-checking bench for the virtual child count decrement leaf
`timescale 1ns/10ps
module test_virtual_child_count_decrement import vccd_pkg::*;;
   // one ordinary case: leaf inputs beside the outcome they should give
   typedef struct {
      logic [63:0] lf;
      logic [1:0] cpl;
      logic ft;
      logic [63:0] tgt;
      logic [3:0] fl;
      logic [7:0] ty;
      logic [63:0] bp;
      logic [63:0] pre;
      vccd_fault_e k;
      logic e;
      logic z;
      logic [63:0] res;
      logic [63:0] cnt;
   } vccd_row_s;

   // short names for the case table
   localparam logic [63:0] A = 64'h5000;
   localparam logic [63:0] B = 64'h3000;
   localparam logic [63:0] X = 64'h7000;
   localparam logic [7:0] RG = VCCD_REGULAR_PAGE_TYPE;
   localparam vccd_fault_e NO = VCCD_F_NONE;
   localparam vccd_fault_e GP = VCCD_F_GP;
   localparam vccd_fault_e PF = VCCD_F_PF;
   localparam vccd_fault_e UD = VCCD_F_UD;

   // fl is {target in memory, parent in memory, target busy, map entry valid}
   vccd_row_s rows [19] = '{
      '{0, 0, 1, A, 4'hd, RG, B, 2, NO, 0, 0, 0, 1},
      '{0, 0, 1, A, 4'he, RG, B, 2, NO, 0, 1, 1, 2},
      '{0, 0, 1, 64'h5008, 4'hd, RG, B, 2, GP, 0, 0, 0, 2},
      '{0, 0, 1, A, 4'hd, VCCD_THREAD_CONTROL_PAGE_TYPE, B, 1, NO, 0, 0, 0, 0},
      '{0, 0, 1, A, 4'hd, RG, B, 0, NO, 0, 1, 2, 0},
      '{0, 0, 1, A, 4'h7, RG, B, 2, PF, 1, 0, 0, 2},
      '{0, 0, 1, A, 4'hb, RG, B, 2, PF, 1, 0, 0, 2},
      '{0, 0, 1, A, 4'hc, RG, B, 2, PF, 1, 0, 0, 2},
      '{0, 0, 1, A, 4'hd, 8'h03, B, 2, PF, 1, 0, 0, 2},
      '{0, 0, 1, A, 4'hd, RG, X, 2, GP, 0, 0, 0, 2},
      '{0, 0, 1, A, 4'hd, VCCD_TRIMMED_PAGE_TYPE, B, 5, NO, 0, 0, 0, 4},
      '{0, 0, 1, A, 4'hd, VCCD_FIRST_SHADOW_STACK_TYPE, B, 4, NO, 0, 0, 0, 3},
      '{0, 0, 1, A, 4'hd, VCCD_LATER_SHADOW_STACK_TYPE, B, 3, NO, 0, 0, 0, 2},
      '{0, 0, 1, A, 4'hd, VCCD_CONTROL_PAGE_TYPE, X, 2, NO, 0, 0, 0, 1},
      '{0, 3, 1, A, 4'hd, RG, B, 2, GP, 0, 0, 0, 2},
      '{0, 0, 0, A, 4'hd, RG, B, 2, UD, 0, 0, 0, 2},
      '{1, 0, 1, A, 4'hd, RG, B, 2, UD, 0, 0, 0, 2},
      '{0, 0, 1, 64'h0000_8000_0000_0000, 4'hd, RG, B, 2, GP, 0, 0, 0, 2},
      '{0, 0, 1, A, 4'hd, RG, B, 64'h1_0000_0000, NO, 0, 0, 0, 64'hffff_ffff}
   };

   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [63:0] reg_wdata = 64'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [63:0] reg_rdata, map_tgt_addr, map_par_addr, d;
   logic map_req, done_pulse, tgt_rw_nonencl, par_rd_encl;
   vccd_ctx_s core_ctx = '0;
   vccd_map_s map_rsp = '0;
   vccd_fault_s fault;
   vccd_flags_s rflags, pf;
   vccd_row_s r;
   int bad_count = 0;
   int checks_done = 0;

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   vccd_leaf_exec dut (
      .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_ctx(core_ctx),
      .map_req(map_req), .map_tgt_addr(map_tgt_addr), .map_par_addr(map_par_addr),
      .map_rsp(map_rsp), .fault(fault), .rflags(rflags), .done_pulse(done_pulse),
      .tgt_rw_nonencl(tgt_rw_nonencl), .par_rd_encl(par_rd_encl)
   );

   // compare one value and count it
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [63:0] v);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // one-cycle register read, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [63:0] v);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      v = reg_rdata;
   endtask

   // load operands, start, watch the lookup and wait for the end
   task automatic leaf(input logic [63:0] lf, input logic [63:0] tgt, input logic [63:0] tl,
                       input logic [63:0] pl);
      wr(VCCD_REG_TGT, tgt);
      wr(VCCD_REG_PAR, 64'h3000);
      wr(VCCD_REG_LEAF, lf);
      wr(VCCD_REG_CTRL, 64'h1);
      for (int i = 0; i < 20 && done_pulse !== 1'b1; i++) begin
         @(posedge ref_clk);
         if (map_req === 1'b1) begin
            check("map_tgt_addr", map_tgt_addr, tl);
            check("map_par_addr", map_par_addr, pl);
            check("access grants", {tgt_rw_nonencl, par_rd_encl}, 2'b11);
         end
      end
      check("done_pulse", done_pulse, 1'b1);
   endtask

   // a hang counts as a mismatch
   initial begin
      #120000;
      bad_count++;
      tally_and_finish();
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      check("idle outputs", {map_req, done_pulse, fault.kind, fault.enclave_fault_error_bit,
                             rflags}, 11'h0);
      check("idle fault addr", fault.addr, 64'h0);
      // case table, counter preset before each leaf
      foreach (rows[i]) begin
         r = rows[i];
         wr(VCCD_REG_CSEL, 64'h3);
         wr(VCCD_REG_CDAT, r.pre);
         core_ctx <= '{cpl: r.cpl, mode64: 1'b1, feature_en: r.ft, default: '0};
         map_rsp <= '{tgt_in_prot: r.fl[3], par_in_prot: r.fl[2], tgt_busy: r.fl[1],
                      valid: r.fl[0], page_type: r.ty, back_ptr: r.bp, tgt_phys: B,
                      par_phys: B};
         pf = rflags;
         leaf(r.lf, r.tgt, r.tgt, B);
         check("fault kind", fault.kind, r.k);
         check("fault enclave bit", fault.enclave_fault_error_bit, r.e);
         check("fault addr", fault.addr, (r.k != PF) ? 64'h0 : r.fl[2] ? r.tgt : B);
         check("flags", rflags, (r.k == NO) ? {r.z, 5'h0} : pf);
         rd(VCCD_REG_LEAF, d);
         check("result", d, (r.k == NO) ? r.res : r.lf);
         wr(VCCD_REG_CSEL, 64'h3);
         rd(VCCD_REG_CDAT, d);
         check("counter", d, r.cnt);
      end
      core_ctx <= '{mode64: 1'b0, feature_en: 1'b1, seg_override: 1'b1, ds_base: 64'h10000,
                    ds_limit: 32'hffff_ffff, default: '0};
      map_rsp.page_type <= RG;
      map_rsp.back_ptr <= B;
      leaf(64'h0, A, 64'h15000, 64'h13000);
      check("fault kind 32", fault.kind, NO);
      core_ctx.ds_limit <= 32'h4fff;
      leaf(64'h0, A, 64'h15000, 64'h13000);
      check("limit fault", fault.kind, GP);
      core_ctx.ds_limit <= 32'hffff_ffff;
      core_ctx.ds_unusable <= 1'b1;
      leaf(64'h0, A, 64'h15000, 64'h13000);
      check("unusable fault", fault.kind, GP);
      rd(VCCD_REG_STAT, d);
      check("status", {d[3:2], d[0]}, 3'b010);
      // unmapped index and read data standing one cycle
      rd(4'hf, d);
      check("unmapped read", d, 64'h0);
      rd(VCCD_REG_CDAT, d);
      @(posedge ref_clk);
      check("read data after", reg_rdata, 64'h0);
      // reset in mid-run clears the fault and the counters
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      check("reset fault", fault.kind, NO);
      wr(VCCD_REG_CSEL, 64'h3);
      rd(VCCD_REG_CDAT, d);
      check("reset counter", d, 64'h0);
      tally_and_finish();
   end
endmodule
